//--- rtl/dgsc_pkg.sv
// Shared constants and types for the dual gain stage serial control link
`default_nettype none
package dgsc_pkg;
  // ************************************************************
  // Word layout
  // ************************************************************
  localparam int WORD_BITS      = 14;
  localparam int GAIN_MSB       = 13;
  localparam int GAIN_LSB       = 8;
  localparam int STAGE_SEL_BIT  = 7;
  localparam int IN_C_BIT       = 6;
  localparam int IN_B_BIT       = 5;
  localparam int IN_A_BIT       = 4;
  localparam int OUT2_MSB       = 3;
  localparam int OUT2_LSB       = 2;
  localparam int OUT1_MSB       = 1;
  localparam int OUT1_LSB       = 0;
  // ************************************************************
  // Gain codes and reset values
  // ************************************************************
  localparam logic [5:0] GAIN_MUTE_CODE = 6'h00;
  localparam logic [5:0] GAIN_MAX_CODE  = 6'h31;
  localparam logic [5:0] GAIN_RESET     = 6'h00;
  localparam logic [2:0] INPUTS_RESET   = 3'h0;
  localparam logic       MUTE_RESET     = 1'b1;
  // ************************************************************
  // Timing: serial clock half period on the host side
  // ************************************************************
  localparam int CLK_PERIOD_NS    = 20;
  localparam int SCLK_HALF_NS     = 250;
  localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ************************************************************
  // Host register offsets
  // ************************************************************
  localparam logic [1:0] ADDR_WORD   = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  // ************************************************************
  // Output drive modes
  // ************************************************************
  typedef enum logic [1:0] {
    DGSC_OUT_HIGHZ  = 2'h0,
    DGSC_OUT_ENABLE = 2'h1,
    DGSC_OUT_NEG    = 2'h2,
    DGSC_OUT_BIAS   = 2'h3
  } dgsc_drive_type;
  localparam dgsc_drive_type DRIVE_RESET = DGSC_OUT_HIGHZ;
endpackage
`default_nettype wire

//--- rtl/dgsc_link_if.sv
// Three-wire serial control link between host and device
`default_nettype none
interface dgsc_link_if;
  logic serial_clk;
  logic serial_data;
  logic latch_strobe;
  modport host   (output serial_clk, output serial_data, output latch_strobe);
  modport device (input serial_clk, input serial_data, input latch_strobe);
endinterface
`default_nettype wire

//--- rtl/dgsc_sync_edge.sv
// Two-flop synchroniser with rising edge pulse
`default_nettype none
module dgsc_sync_edge (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Pin in, level and edge out
  input  wire logic pin_in,
  output logic      level,
  output logic      rise
);
  logic meta;
  logic sync;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_prev;
  // Next values
  always_comb begin
    next_meta = pin_in;
    next_sync = meta;
    next_prev = sync;
  end
  // Registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta <= 1'b1;
      sync <= 1'b1;
      prev <= 1'b1;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end
  assign level = sync;
  assign rise  = sync & ~prev;
endmodule
`default_nettype wire

//--- rtl/dgsc_device.sv
// Device end: serial shift register and two stage settings registers
// What this block does
// - Sample data on serial rising edge, MSB first
// - Host holds strobe high while shifting
// - Host pulses strobe high-low-high after fourteen bits
// - Commit word on strobe rising edge only
// - Shifting never changes active settings
// - Bit 7 picks stage; stages independent
// - Bits 13-8 gain code, 2 dB steps
// - Gain code zero mutes the stage
// - Bits 4-6 enable inputs a, b, c; stage two ignores bit 6
// - Bits 1-0 set primary output drive
// - Bits 3-2 set stage one secondary drive
// - Host idles serial clock between words

// Both stages come out of reset muted, with no input selected
// and every output drive at high impedance.
`default_nettype none
module dgsc_device
  import dgsc_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                resetn,
  // Serial link
  dgsc_link_if.device              link,
  // Stage one settings
  output logic [5:0]               stage_one_gain,
  output logic                     stage_one_mute,
  output logic                     stage_one_input_a,
  output logic                     stage_one_input_b,
  output logic                     stage_one_input_c,
  output dgsc_pkg::dgsc_drive_type stage_one_primary_out,
  output dgsc_pkg::dgsc_drive_type stage_one_secondary_out,
  // Stage two settings
  output logic [5:0]               stage_two_gain,
  output logic                     stage_two_mute,
  output logic                     stage_two_input_a,
  output logic                     stage_two_input_b,
  output dgsc_pkg::dgsc_drive_type stage_two_out
);
  import dgsc_pkg::*;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic sclk_rise;
  logic data_level;
  logic latch_rise;

  // Clock and data pass the same two flops, so the data level seen
  // beside a detected clock rise is the one the host set up for it
  dgsc_sync_edge u_sclk (
    .clk    (clk),
    .resetn (resetn),
    .pin_in (link.serial_clk),
    .level  (),
    .rise   (sclk_rise)
  );
  dgsc_sync_edge u_data (
    .clk    (clk),
    .resetn (resetn),
    .pin_in (link.serial_data),
    .level  (data_level),
    .rise   ()
  );
  dgsc_sync_edge u_latch (
    .clk    (clk),
    .resetn (resetn),
    .pin_in (link.latch_strobe),
    .level  (),
    .rise   (latch_rise)
  );

  // ************************************************************
  // Shift register
  // ************************************************************
  logic [WORD_BITS-1:0] shift;
  logic [WORD_BITS-1:0] next_shift;

  // Shift one bit in at each serial clock rise
  // Extra bits push the oldest out, so the last fourteen count
  always_comb begin
    next_shift = shift;
    if (sclk_rise) begin
      next_shift = {shift[WORD_BITS-2:0], data_level};
    end
  end

  // Register the shift word
  always_ff @(posedge clk) begin
    if (!resetn) begin
      shift <= '0;
    end else begin
      shift <= next_shift;
    end
  end

  // ************************************************************
  // Word decode
  // ************************************************************
  logic [5:0] word_gain;
  logic       word_mute;

  // Gain field with clamp of undocumented codes
  always_comb begin
    word_gain = shift[GAIN_MSB:GAIN_LSB];
    // Codes above the top step store the top step code
    // Clamp high codes
    if (word_gain > GAIN_MAX_CODE) begin
      word_gain = GAIN_MAX_CODE;
    end
    // Mute follows the raw code, not the clamped one
    // Zero code mutes
    word_mute = (shift[GAIN_MSB:GAIN_LSB] == GAIN_MUTE_CODE);
  end

  // ************************************************************
  // Stage settings registers
  // ************************************************************
  logic [5:0]     s1_gain, next_s1_gain, s2_gain, next_s2_gain;
  logic           s1_mute, next_s1_mute, s2_mute, next_s2_mute;
  logic [2:0]     s1_in, next_s1_in;
  logic [1:0]     s2_in, next_s2_in;
  dgsc_drive_type s1_pri, next_s1_pri, s1_sec, next_s1_sec;
  dgsc_drive_type s2_pri, next_s2_pri;

  // The synchronised strobe edge lands two cycles after the pin rise
  // Commit shifted word into the addressed stage
  always_comb begin
    next_s1_gain = s1_gain;
    next_s1_mute = s1_mute;
    next_s1_in   = s1_in;
    next_s1_pri  = s1_pri;
    next_s1_sec  = s1_sec;
    next_s2_gain = s2_gain;
    next_s2_mute = s2_mute;
    next_s2_in   = s2_in;
    next_s2_pri  = s2_pri;
    if (latch_rise) begin
      if (!shift[STAGE_SEL_BIT]) begin
        next_s1_gain = word_gain;
        next_s1_mute = word_mute;
        next_s1_in   = {shift[IN_C_BIT], shift[IN_B_BIT], shift[IN_A_BIT]};
        next_s1_pri  = dgsc_drive_type'(shift[OUT1_MSB:OUT1_LSB]);
        next_s1_sec  = dgsc_drive_type'(shift[OUT2_MSB:OUT2_LSB]);
      end else begin
        next_s2_gain = word_gain;
        next_s2_mute = word_mute;
        // Input c and secondary bits ignored
        next_s2_in   = {shift[IN_B_BIT], shift[IN_A_BIT]};
        next_s2_pri  = dgsc_drive_type'(shift[OUT1_MSB:OUT1_LSB]);
      end
    end
  end

  // Register both stages' settings
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_gain <= GAIN_RESET;
      s1_mute <= MUTE_RESET;
      s1_in   <= INPUTS_RESET;
      s1_pri  <= DRIVE_RESET;
      s1_sec  <= DRIVE_RESET;
      s2_gain <= GAIN_RESET;
      s2_mute <= MUTE_RESET;
      s2_in   <= INPUTS_RESET[1:0];
      s2_pri  <= DRIVE_RESET;
    end else begin
      s1_gain <= next_s1_gain;
      s1_mute <= next_s1_mute;
      s1_in   <= next_s1_in;
      s1_pri  <= next_s1_pri;
      s1_sec  <= next_s1_sec;
      s2_gain <= next_s2_gain;
      s2_mute <= next_s2_mute;
      s2_in   <= next_s2_in;
      s2_pri  <= next_s2_pri;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Outputs straight from the settings flops, no logic in between
  assign stage_one_gain          = s1_gain;
  assign stage_one_mute          = s1_mute;
  assign stage_one_input_a       = s1_in[0];
  assign stage_one_input_b       = s1_in[1];
  assign stage_one_input_c       = s1_in[2];
  assign stage_one_primary_out   = s1_pri;
  assign stage_one_secondary_out = s1_sec;
  assign stage_two_gain          = s2_gain;
  assign stage_two_mute          = s2_mute;
  assign stage_two_input_a       = s2_in[0];
  assign stage_two_input_b       = s2_in[1];
  assign stage_two_out           = s2_pri;
endmodule
`default_nettype wire

//--- rtl/dgsc_host.sv
// Host end: register port, serial word sender with latch strobe
`default_nettype none
module dgsc_host
  import dgsc_pkg::*;
#(
  parameter int HALF_CYCLES = SCLK_HALF_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Register port
  input  wire logic [1:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [15:0]      rdata,
  // Serial link
  dgsc_link_if.host        link
);
  import dgsc_pkg::*;

  // ************************************************************
  // Parameter check
  // ************************************************************
  // Refuse a half period that the 16-bit timer cannot count
  if (HALF_CYCLES < 1 || HALF_CYCLES > 65536) begin : g_bad_half
    $error("HALF_CYCLES out of range");
  end

  typedef enum {IDLE, LOW, HIGH, LATCH_LOW, LATCH_HIGH} dgsc_state_type;

  dgsc_state_type       state, next_state;
  logic [WORD_BITS-1:0] word, next_word;
  logic [3:0]           bit_cnt, next_bit_cnt;
  logic [15:0]          timer, next_timer;
  logic                 sclk, next_sclk, sdata, next_sdata, strobe, next_strobe;
  logic [15:0]          next_rdata;
  logic                 timer_done;

  assign timer_done = (timer == 16'(HALF_CYCLES - 1));

  // Sequencer: clock out 14 bits then strobe low and high again
  always_comb begin
    next_state   = state;
    next_word    = word;
    next_bit_cnt = bit_cnt;
    next_timer   = timer_done ? 16'h0000 : timer + 16'h0001;
    next_sclk    = sclk;
    next_sdata   = sdata;
    next_strobe  = strobe;
    next_rdata   = 16'h0000;
    if (rd) begin
      if (addr == ADDR_WORD) begin
        next_rdata = {2'h0, word};
      end else if (addr == ADDR_STATUS) begin
        next_rdata = {15'h0000, state != IDLE};
      end
    end
    unique case (state)
      IDLE: begin
        next_timer = 16'h0000;
        if (wr && addr == ADDR_WORD) begin
          next_word    = wdata[WORD_BITS-1:0];
          next_bit_cnt = 4'h0;
          next_sdata   = wdata[WORD_BITS-1];
          next_state   = LOW;
        end
      end
      LOW: begin
        if (timer_done) begin
          next_sclk  = 1'b1;
          next_state = HIGH;
        end
      end
      HIGH: begin
        if (timer_done) begin
          next_sclk = 1'b0;
          if (bit_cnt == 4'(WORD_BITS - 1)) begin
            next_strobe = 1'b0;
            next_state  = LATCH_LOW;
          end else begin
            next_bit_cnt = bit_cnt + 4'h1;
            next_sdata   = word[4'(WORD_BITS - 2) - bit_cnt];
            next_state   = LOW;
          end
        end
      end
      LATCH_LOW: begin
        if (timer_done) begin
          next_strobe = 1'b1;
          next_state  = LATCH_HIGH;
        end
      end
      LATCH_HIGH: begin
        if (timer_done) begin
          next_state = IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state   <= IDLE;
      word    <= '0;
      bit_cnt <= 4'h0;
      timer   <= 16'h0000;
      sclk    <= 1'b0;
      sdata   <= 1'b0;
      strobe  <= 1'b1;
      rdata   <= 16'h0000;
    end else begin
      state   <= next_state;
      word    <= next_word;
      bit_cnt <= next_bit_cnt;
      timer   <= next_timer;
      sclk    <= next_sclk;
      sdata   <= next_sdata;
      strobe  <= next_strobe;
      rdata   <= next_rdata;
    end
  end

  assign link.serial_clk   = sclk;
  assign link.serial_data  = sdata;
  assign link.latch_strobe = strobe;
endmodule
`default_nettype wire

//--- tb/dgsc_props.sv
// Assertions on the serial control link and the settings it commits
`default_nettype none
module dgsc_props (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Serial link
  input  wire logic       serial_clk,
  input  wire logic       serial_data,
  input  wire logic       latch_strobe,
  // Committed settings
  input  wire logic [5:0] stage_one_gain,
  input  wire logic       stage_one_mute,
  input  wire logic [5:0] stage_two_gain,
  input  wire logic       stage_two_mute
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] bits;
  logic [3:0] hi;
  logic       sclk_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Count link clock rises per word and cycles since the strobe rose
  always_ff @(posedge clk) begin
    sclk_q <= serial_clk;
    if (!resetn || !latch_strobe) begin
      bits <= 4'h0;
    end else if (serial_clk && !sclk_q) begin
      bits <= bits + 4'h1;
    end
    if (!resetn) begin
      hi <= 4'hF;
    end else if (!latch_strobe) begin
      hi <= 4'h0;
    end else if (hi != 4'hF) begin
      hi <= hi + 4'h1;
    end
  end
  property p_data_stable;
    $rose(serial_clk) |-> $stable(serial_data);
  endproperty
  a_data_stable: assert property (p_data_stable)
    else $error("serial data moved at clock rise");
  property p_shift_strobe;
    serial_clk |-> latch_strobe;
  endproperty
  a_shift_strobe: assert property (p_shift_strobe)
    else $error("strobe low while link clock high");
  property p_fourteen;
    $fell(latch_strobe) |-> bits == 4'hE;
  endproperty
  a_fourteen: assert property (p_fourteen)
    else $error("word length not fourteen");
  property p_no_extra;
    $rose(serial_clk) |-> bits < 4'hE;
  endproperty
  a_no_extra: assert property (p_no_extra)
    else $error("extra link clock in word");
  property p_pulse;
    $fell(latch_strobe) |-> ##[1:8] latch_strobe;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("strobe low pulse too long");
  property p_commit;
    $changed({stage_one_gain, stage_one_mute, stage_two_gain, stage_two_mute})
      |-> hi >= 4'h1 && hi <= 4'h7;
  endproperty
  a_commit: assert property (p_commit)
    else $error("settings changed away from strobe rise");
  property p_mute_one;
    stage_one_mute == (stage_one_gain == 6'h00);
  endproperty
  a_mute_one: assert property (p_mute_one)
    else $error("stage one mute and gain disagree");
  property p_mute_two;
    stage_two_mute == (stage_two_gain == 6'h00);
  endproperty
  a_mute_two: assert property (p_mute_two)
    else $error("stage two mute and gain disagree");
  property p_clamp;
    stage_one_gain <= 6'h31 && stage_two_gain <= 6'h31;
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("gain above maximum code");
endmodule
`default_nettype wire

//--- tb/test_dual_gain_stage_serial_control.sv
// Testbench: host and device ends joined over the serial control link
`default_nettype none
module test_dual_gain_stage_serial_control;
  timeunit 1ns;
  timeprecision 1ps;
  import dgsc_pkg::*;
  logic           clk;
  logic           resetn;
  logic [1:0]     addr;
  logic [15:0]    wdata;
  logic           wr;
  logic           rd;
  logic [15:0]    rdata;
  logic [5:0]     g1;
  logic [5:0]     g2;
  logic           m1, a1, b1, c1, m2, a2, b2;
  dgsc_drive_type p1, s1, o2;
  logic [15:0]    e1, e2, d;
  int             err_count = 0;
  int             n_compared = 0;
  logic [19:0]    rows [7] = '{{14'h0079, 6'h00}, {14'h011C, 6'h01}, {14'h19FE, 6'h19},
    {14'h3121, 6'h31}, {14'h3393, 6'h31}, {14'h3F46, 6'h31}, {14'h3280, 6'h31}};
  wire [15:0] act1 = {2'h0, g1, m1, c1, b1, a1, s1, p1};
  wire [15:0] act2 = {5'h0, g2, m2, b2, a2, o2};
  dgsc_link_if dgsc_link_if_i ();
  dgsc_host #(.HALF_CYCLES(2)) dgsc_host_i (.clk(clk), .resetn(resetn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link(dgsc_link_if_i));
  dgsc_device dgsc_device_i (.clk(clk), .resetn(resetn), .link(dgsc_link_if_i),
    .stage_one_gain(g1), .stage_one_mute(m1), .stage_one_input_a(a1),
    .stage_one_input_b(b1), .stage_one_input_c(c1), .stage_one_primary_out(p1),
    .stage_one_secondary_out(s1), .stage_two_gain(g2), .stage_two_mute(m2),
    .stage_two_input_a(a2), .stage_two_input_b(b2), .stage_two_out(o2));
  dgsc_props dgsc_props_i (.clk(clk), .resetn(resetn),
    .serial_clk(dgsc_link_if_i.serial_clk), .serial_data(dgsc_link_if_i.serial_data),
    .latch_strobe(dgsc_link_if_i.latch_strobe), .stage_one_gain(g1),
    .stage_one_mute(m1), .stage_two_gain(g2), .stage_two_mute(m2));
  // Clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input logic [15:0] act, input logic [15:0] exp);
    n_compared++;
    if (act !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, act, exp);
    end
  endtask
  // One register write cycle
  task automatic wr_reg(input logic [1:0] a, input logic [15:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // Let an edge pass so a following write never raises wr in this step
    @(posedge clk);
  endtask
  // One register read; data taken in the following cycle
  task automatic rd_reg(input logic [1:0] a, output logic [15:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask
  // Send a word, check nothing moves mid shift, then check the commit
  task automatic send(input logic [13:0] w, input logic [5:0] eg, input bit x);
    wr_reg(2'h0, {2'h0, w});
    if (x) begin
      wr_reg(2'h0, 16'h3F80);
      wr_reg(2'h2, 16'h1234);
    end
    repeat (16) @(posedge clk);
    chk(act1, e1);
    chk(act2, e2);
    d = 16'h1;
    for (int i = 0; i < 100 && d[0] !== 1'b0; i++) rd_reg(2'h1, d);
    chk(d, 16'h0000);
    chk({15'h0000, dgsc_link_if_i.serial_clk}, 16'h0000);
    repeat (6) @(posedge clk);
    if (w[7]) e2 = {5'h0, eg, eg == 6'h00, w[5:4], w[1:0]};
    else e1 = {2'h0, eg, eg == 6'h00, w[6:4], w[3:2], w[1:0]};
    chk(act1, e1);
    chk(act2, e2);
  endtask
  // Verdict
  task automatic finish_test;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #400000;
    err_count++;
    finish_test();
  end
  // Main sequence
  initial begin
    resetn = 1'b0;
    addr = 2'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    e1 = 16'h0080;
    e2 = 16'h0010;
    repeat (3) @(posedge clk);
    chk(act1, e1);
    chk(act2, e2);
    resetn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 7; i++) send(rows[i][19:6], rows[i][5:0], 1'b0);
    // Writes while busy and to other addresses are ignored
    send(14'h0155, 6'h01, 1'b1);
    rd_reg(2'h0, d);
    chk(d, 16'h0155);
    rd_reg(2'h2, d);
    chk(d, 16'h0000);
    // Reset in the middle of a word
    wr_reg(2'h0, 16'h3FFF);
    repeat (10) @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    e1 = 16'h0080;
    e2 = 16'h0010;
    chk(act1, e1);
    chk(act2, e2);
    resetn <= 1'b1;
    @(posedge clk);
    send(14'h3391, 6'h31, 1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
